// ==== shared/bcm_pkg.sv ====
// Shared constants, operation codes and decode for the burst counter block
// Behaviour
// R1 - Counter mode: clear resets, else load, readback, increment or hold
// R2 - Mask select: clear resets mask, strobe low loads or reads the mask
// R3 - Master reset asynchronous; clocked controls ignore chip selects
// R4 - Counter reset zeroes unmasked counter and mirror bits, masked bits kept
// R5 - Mask reset then counter reset leaves counter and mirror all zero
// R6 - Counter load writes the address inputs into counter and mirror
// R7 - Counter readback drives the counter onto address lines one edge later
// R8 - Readback while the port is selected tri-states the data lines
// R9 - Increment changes unmasked bits only, by one, or two when bit 0 masked
// R10 - Increment from all-ones unmasked part restores mirror value
// R11 - Wrap flag low when increment gives all ones, high otherwise
// R12 - Wrap flag high after counter or mask reset or load, master reset
// R13 - Host may tie the wrap flag to counter clear to loop to zero
// R14 - Hold keeps counter, mask and mirror unchanged indefinitely
// R15 - Mask reset and master reset set every mask bit to one
// R16 - Mask load writes the address inputs into the mask register
// R17 - Host loads only masks of form two-to-the-n minus one or two
// R18 - Mask readback on address lines next edge, data tri-stated if selected
// R19 - Registers are 17 bits wide by default, 16 or 15 in smaller builds
// R20 - Reserved mask-mode strobe-high combination changes nothing
package bcm_pkg;

  localparam int ADDR_W_DEF = 17;
  localparam int ADDR_W_MAX = 17;
  localparam int SYNC_STAGES = 3;

  localparam logic [ADDR_W_MAX-1:0] CNT_RST_VAL = 17'h00000;
  localparam logic [ADDR_W_MAX-1:0] MIRROR_RST_VAL = 17'h00000;
  localparam logic [ADDR_W_MAX-1:0] MASK_RST_VAL = 17'h1FFFF;
  localparam logic WRAP_IDLE = 1'b1;
  localparam logic OE_N_IDLE = 1'b1;

  typedef enum logic [3:0]
  {
    op_cnt_reset = 4'h0,
    op_cnt_load = 4'h1,
    op_cnt_read = 4'h2,
    op_cnt_inc = 4'h3,
    op_cnt_hold = 4'h4,
    op_msk_reset = 4'h5,
    op_msk_load = 4'h6,
    op_msk_read = 4'h7,
    op_reserved = 4'h8
  } op_t;

  // Control pin decode, clear has priority over strobe and enable
  function automatic op_t decode_op(input logic sel, input logic clr_n,
                                    input logic stb_n, input logic en_n);
    op_t op;
    op = op_cnt_hold;
    if (sel)
    begin
      if (!clr_n)
        op = op_cnt_reset;
      else if (!stb_n && !en_n)
        op = op_cnt_load;
      else if (!stb_n)
        op = op_cnt_read;
      else if (!en_n)
        op = op_cnt_inc;
      else
        op = op_cnt_hold;
    end
    else
    begin
      if (!clr_n)
        op = op_msk_reset;
      else if (!stb_n && !en_n)
        op = op_msk_load;
      else if (!stb_n)
        op = op_msk_read;
      else
        op = op_reserved;
    end
    return op;
  endfunction

endpackage

// ==== rtl/bcm_reset_release.sv ====
// Master reset conditioner: immediate assertion, synchronised release
`timescale 1ns/1ps
`default_nettype none
module bcm_reset_release
  import bcm_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Asynchronous pin
  input wire logic master_reset_n,
  // Conditioned reset
  output logic arst_n
);

  logic [SYNC_STAGES-1:0] stage_q;

  // Flops take only constants under the asynchronous reset
  always_ff @(posedge clk_sys or negedge master_reset_n)
  begin
    if (!master_reset_n)
      stage_q <= '0;
    else
      stage_q <= {stage_q[SYNC_STAGES-2:0], 1'b1};
  end

  // Release counts once the last two stages both hold one
  assign arst_n = stage_q[SYNC_STAGES-1] & stage_q[SYNC_STAGES-2];

endmodule
`default_nettype wire

// ==== rtl/bcm_masked_incrementer.sv ====
// Masked increment with wrap to the mirrored start address
`timescale 1ns/1ps
`default_nettype none
module bcm_masked_incrementer
#(
  parameter int ADDR_W = 17
)
(
  // Current state
  input wire logic [ADDR_W-1:0] cnt,
  input wire logic [ADDR_W-1:0] mask,
  input wire logic [ADDR_W-1:0] mirror,
  // Result of one increment
  output logic [ADDR_W-1:0] next_cnt,
  output logic next_full,
  output logic cur_full
);

  function automatic logic unmasked_full(input logic [ADDR_W-1:0] v,
                                         input logic [ADDR_W-1:0] m);
    return (v & m) == m;
  endfunction

  logic [ADDR_W-1:0] step;
  logic [ADDR_W-1:0] sum;

  always_comb
  begin
    step = mask[0] ? ADDR_W'(1) : ADDR_W'(2); // R9
    sum = cnt + step;
    cur_full = unmasked_full(cnt, mask);
    // Wrap restores the start address but keeps masked bits
    if (cur_full)
      next_cnt = (cnt & ~mask) | (mirror & mask); // R9 R10
    else
      next_cnt = (cnt & ~mask) | (sum & mask); // R9
    next_full = unmasked_full(next_cnt, mask); // R11
  end

endmodule
`default_nettype wire

// ==== rtl/burst_counter_mask_mirror.sv ====
// Per-port burst address counter with mask and mirror registers
`timescale 1ns/1ps
`default_nettype none
module burst_counter_mask_mirror
  import bcm_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF // R19
)
(
  // Clock and resets
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic master_reset_n,
  // Counter controls
  input wire logic counter_or_mask_select,
  input wire logic counter_clear_n,
  input wire logic address_strobe_n,
  input wire logic count_enable_n,
  // Port selects
  input wire logic chip_select_low_active,
  input wire logic chip_select_high_active,
  // Address pins
  input wire logic [ADDR_W-1:0] addr_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic addr_oe_n,
  // Data pin release during readback
  output logic data_tristate,
  // Array address and status
  output logic [ADDR_W-1:0] counter_addr,
  output logic [ADDR_W-1:0] mask_value,
  output logic wrap_flag_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset conditioning

  logic arst_n;

  bcm_reset_release u_rst
  (
    .clk_sys(clk_sys),
    .master_reset_n(master_reset_n),
    .arst_n(arst_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode

  op_t op;
  logic port_sel;

  always_comb
  begin
    op = decode_op(counter_or_mask_select, counter_clear_n,
                   address_strobe_n, count_enable_n); // R1 R2
    port_sel = !chip_select_low_active && chip_select_high_active;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, mask and mirror

  logic [ADDR_W-1:0] cnt_q;
  logic [ADDR_W-1:0] cnt_d;
  logic [ADDR_W-1:0] mask_q;
  logic [ADDR_W-1:0] mask_d;
  logic [ADDR_W-1:0] mirror_q;
  logic [ADDR_W-1:0] mirror_d;
  logic wrap_q;
  logic wrap_d;
  logic [ADDR_W-1:0] inc_cnt;
  logic inc_full;
  logic cur_full;

  bcm_masked_incrementer #(.ADDR_W(ADDR_W)) u_inc
  (
    .cnt(cnt_q),
    .mask(mask_q),
    .mirror(mirror_q),
    .next_cnt(inc_cnt),
    .next_full(inc_full),
    .cur_full(cur_full)
  );

  always_comb
  begin
    cnt_d = cnt_q;
    mask_d = mask_q;
    mirror_d = mirror_q;
    wrap_d = wrap_q;
    case (op)
      op_cnt_reset:
      begin
        cnt_d = cnt_q & ~mask_q; // R4
        mirror_d = mirror_q & ~mask_q; // R4
        wrap_d = 1'b1; // R12
      end
      op_cnt_load:
      begin
        cnt_d = addr_in; // R6
        mirror_d = addr_in; // R6
        wrap_d = 1'b1; // R12
      end
      op_cnt_inc:
      begin
        cnt_d = inc_cnt; // R9 R10
        wrap_d = !inc_full; // R11
      end
      op_msk_reset:
      begin
        mask_d = MASK_RST_VAL[ADDR_W-1:0]; // R15
        wrap_d = 1'b1; // R12
      end
      op_msk_load:
      begin
        mask_d = addr_in; // R16
        wrap_d = 1'b1; // R12
      end
      default:
      begin
        // Hold, readbacks and reserved leave everything alone
        cnt_d = cnt_q; // R14 R20
      end
    endcase
  end

  // Master reset bypasses the clock; controls ignore the chip selects
  always_ff @(posedge clk_sys or negedge arst_n) // R3
  begin
    if (!arst_n)
    begin
      cnt_q <= CNT_RST_VAL[ADDR_W-1:0];
      mask_q <= MASK_RST_VAL[ADDR_W-1:0]; // R15
      mirror_q <= MIRROR_RST_VAL[ADDR_W-1:0];
      wrap_q <= WRAP_IDLE; // R12
    end
    else if (srst)
    begin
      cnt_q <= CNT_RST_VAL[ADDR_W-1:0];
      mask_q <= MASK_RST_VAL[ADDR_W-1:0];
      mirror_q <= MIRROR_RST_VAL[ADDR_W-1:0];
      wrap_q <= WRAP_IDLE;
    end
    else
    begin
      cnt_q <= cnt_d;
      mask_q <= mask_d;
      mirror_q <= mirror_d;
      wrap_q <= wrap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pipelined readback on the address pins

  logic rb_req_q;
  logic rb_req_d;
  logic rb_sel_q;
  logic rb_sel_d;
  logic [ADDR_W-1:0] rb_val_q;
  logic [ADDR_W-1:0] rb_val_d;
  logic [ADDR_W-1:0] addr_out_q;
  logic [ADDR_W-1:0] addr_out_d;
  logic addr_oe_n_q;
  logic addr_oe_n_d;
  logic dq_off_q;
  logic dq_off_d;

  always_comb
  begin
    rb_req_d = (op == op_cnt_read) || (op == op_msk_read);
    rb_sel_d = rb_req_d && port_sel;
    rb_val_d = (op == op_msk_read) ? mask_q : cnt_q; // R7 R18
    addr_out_d = rb_req_q ? rb_val_q : addr_out_q;
    addr_oe_n_d = !rb_req_q; // R7 R18
    dq_off_d = rb_sel_q; // R8 R18
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rb_req_q <= 1'b0;
      rb_sel_q <= 1'b0;
      rb_val_q <= CNT_RST_VAL[ADDR_W-1:0];
      addr_out_q <= CNT_RST_VAL[ADDR_W-1:0];
      addr_oe_n_q <= OE_N_IDLE;
      dq_off_q <= 1'b0;
    end
    else if (srst)
    begin
      rb_req_q <= 1'b0;
      rb_sel_q <= 1'b0;
      rb_val_q <= CNT_RST_VAL[ADDR_W-1:0];
      addr_out_q <= CNT_RST_VAL[ADDR_W-1:0];
      addr_oe_n_q <= OE_N_IDLE;
      dq_off_q <= 1'b0;
    end
    else
    begin
      rb_req_q <= rb_req_d;
      rb_sel_q <= rb_sel_d;
      rb_val_q <= rb_val_d;
      addr_out_q <= addr_out_d;
      addr_oe_n_q <= addr_oe_n_d;
      dq_off_q <= dq_off_d;
    end
  end

  assign addr_out = addr_out_q;
  assign addr_oe_n = addr_oe_n_q;
  assign data_tristate = dq_off_q;
  assign counter_addr = cnt_q;
  assign mask_value = mask_q;
  assign wrap_flag_n = wrap_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_clear_unmasked: assert property (@(posedge clk_sys) // R4
    disable iff (srst || !arst_n)
    op == op_cnt_reset |=> cnt_q == ($past(cnt_q) & ~$past(mask_q))
      && mirror_q == ($past(mirror_q) & ~$past(mask_q)))
    else $error("counter reset did not clear unmasked bits");

  a_zero_after_unmask: assert property (@(posedge clk_sys) // R5
    disable iff (srst || !arst_n)
    op == op_msk_reset ##1 op == op_cnt_reset |=>
      cnt_q == '0 && mirror_q == '0)
    else $error("mask then counter reset did not give zero");

  a_load_both: assert property (@(posedge clk_sys) // R6
    disable iff (srst || !arst_n)
    op == op_cnt_load |=> cnt_q == $past(addr_in)
      && mirror_q == $past(addr_in))
    else $error("counter load missed counter or mirror");

  a_count_readback: assert property (@(posedge clk_sys) // R7
    disable iff (srst || !arst_n)
    op == op_cnt_read |-> ##2 !addr_oe_n_q
      && addr_out_q == $past(cnt_q, 2))
    else $error("counter readback wrong value or timing");

  a_data_released: assert property (@(posedge clk_sys) // R8
    disable iff (srst || !arst_n)
    (op == op_cnt_read || op == op_msk_read) && port_sel |-> ##2 dq_off_q)
    else $error("data lines not released on readback");

  a_masked_bits_kept: assert property (@(posedge clk_sys) // R9
    disable iff (srst || !arst_n)
    op == op_cnt_inc && !cur_full |=>
      ((cnt_q ^ $past(cnt_q)) & ~$past(mask_q)) == '0
      && (cnt_q & mask_q) == (($past(cnt_q) + ($past(mask_q[0]) ?
         ADDR_W'(1) : ADDR_W'(2))) & mask_q))
    else $error("increment touched masked bits or wrong step");

  a_wrap_to_mirror: assert property (@(posedge clk_sys) // R10
    disable iff (srst || !arst_n)
    op == op_cnt_inc && cur_full |=> cnt_q == (($past(cnt_q)
      & ~$past(mask_q)) | ($past(mirror_q) & $past(mask_q))))
    else $error("wrap did not restore mirror value");

  a_wrap_flag_level: assert property (@(posedge clk_sys) // R11
    disable iff (srst || !arst_n)
    op == op_cnt_inc |=> wrap_flag_n == ((cnt_q & mask_q) != mask_q))
    else $error("wrap flag does not match counter");

  a_flag_released: assert property (@(posedge clk_sys) // R12
    disable iff (srst || !arst_n)
    op inside {op_cnt_reset, op_cnt_load, op_msk_reset, op_msk_load}
      |=> wrap_flag_n)
    else $error("wrap flag not returned high");

  a_hold_stable: assert property (@(posedge clk_sys) // R14
    disable iff (srst || !arst_n)
    (op == op_cnt_hold) [*3] |=> $stable(cnt_q) && $stable(mask_q)
      && $stable(mirror_q) && $stable(wrap_q))
    else $error("hold changed a register");

  a_mask_all_ones: assert property (@(posedge clk_sys) // R15
    disable iff (srst || !arst_n)
    op == op_msk_reset |=> &mask_q)
    else $error("mask reset did not set all ones");

  a_mask_load: assert property (@(posedge clk_sys) // R16
    disable iff (srst || !arst_n)
    op == op_msk_load |=> mask_q == $past(addr_in) && $stable(cnt_q))
    else $error("mask load wrong");

  a_mask_readback: assert property (@(posedge clk_sys) // R18
    disable iff (srst || !arst_n)
    op == op_msk_read |-> ##2 !addr_oe_n_q
      && addr_out_q == $past(mask_q, 2))
    else $error("mask readback wrong value or timing");

  a_reserved_idle: assert property (@(posedge clk_sys) // R20
    disable iff (srst || !arst_n)
    op == op_reserved |=> $stable(cnt_q) && $stable(mask_q)
      && $stable(mirror_q) && $stable(wrap_q))
    else $error("reserved operation changed state");

endmodule
`default_nettype wire

// ==== sim/bcm_host_model.sv ====
// Host model driving the counter control and address pins
`timescale 1ns/1ps
`default_nettype none
module bcm_host_model
#(
  parameter int ADDR_W = 17
)
(
  // Clock
  input wire logic clk_sys,
  // Requests
  input wire logic [3:0] op,
  input wire logic [ADDR_W-1:0] data,
  input wire logic tie_wrap,
  // Design side
  input wire logic wrap_flag_n,
  input wire logic addr_oe_n,
  input wire logic [ADDR_W-1:0] addr_out,
  // Pins
  output logic counter_or_mask_select,
  output logic counter_clear_n,
  output logic address_strobe_n,
  output logic count_enable_n,
  output logic [ADDR_W-1:0] addr_pins
);
  import bcm_pkg::*;
  logic [ADDR_W-1:0] last_q = '0;
  logic ld;
  always_comb
  begin
    ld = op == op_cnt_load || op == op_msk_load;
    counter_or_mask_select = op <= op_cnt_hold;
    counter_clear_n = !(op == op_cnt_reset || op == op_msk_reset)
      && (wrap_flag_n || !tie_wrap);
    address_strobe_n = !(ld || op == op_cnt_read || op == op_msk_read);
    count_enable_n = !(ld || op == op_cnt_inc);
    // Released pins show a changing pattern
    addr_pins = ld ? data : (addr_oe_n ? ~last_q : addr_out);
  end
  always_ff @(posedge clk_sys)
    last_q <= addr_pins;
endmodule
`default_nettype wire

// ==== sim/burst_counter_mask_mirror_tb_top.sv ====
// Self-checking bench for the burst counter with mask and mirror
`timescale 1ns/1ps
`default_nettype none
module burst_counter_mask_mirror_tb_top;
  import bcm_pkg::*;
  localparam int AW = 17;
  localparam int ALL = 32'h0001FFFF;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic master_reset_n = 1'h1;
  logic [3:0] op = 4'h4;
  logic [AW-1:0] data = '0;
  logic tie_wrap = 1'h0;
  logic ce_lo = 1'h1;
  logic ce_hi = 1'h0;
  logic sel, clr_n, stb_n, en_n;
  logic [AW-1:0] addr_in, addr_out, counter_addr, mask_value;
  logic addr_oe_n, data_tristate, wrap_flag_n;
  logic [3:0] ro;
  logic [AW-1:0] rd;
  int fails = 0;
  int n_tests = 0;
  int seed = 30433;
  int n, e_cnt, e_msk, e_mir, e_wrap;
  int rb0_v, rb0_d, rb0_t, rb1_v, rb1_d, rb1_t;

  burst_counter_mask_mirror #(.ADDR_W(AW)) i_dut (
    .clk_sys(clk_sys), .srst(srst), .master_reset_n(master_reset_n),
    .counter_or_mask_select(sel), .counter_clear_n(clr_n),
    .address_strobe_n(stb_n), .count_enable_n(en_n),
    .chip_select_low_active(ce_lo), .chip_select_high_active(ce_hi),
    .addr_in(addr_in), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
    .data_tristate(data_tristate), .counter_addr(counter_addr),
    .mask_value(mask_value), .wrap_flag_n(wrap_flag_n));

  bcm_host_model #(.ADDR_W(AW)) i_host (
    .clk_sys(clk_sys), .op(op), .data(data), .tie_wrap(tie_wrap),
    .wrap_flag_n(wrap_flag_n), .addr_oe_n(addr_oe_n),
    .addr_out(addr_out), .counter_or_mask_select(sel),
    .counter_clear_n(clr_n), .address_strobe_n(stb_n),
    .count_enable_n(en_n), .addr_pins(addr_in));

  initial
  forever
    #25 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic model_reset;
    e_cnt = 0;
    e_msk = ALL;
    e_mir = 0;
    e_wrap = 1;
    rb0_v = 0;
    rb1_v = 0;
  endtask

  // Check last edge's results, then issue one operation
  task automatic step(input logic [3:0] o, input logic [AW-1:0] d);
    logic [3:0] eo;
    @(negedge clk_sys);
    check(counter_addr, e_cnt);
    check(mask_value, e_msk);
    check(wrap_flag_n, e_wrap);
    check(addr_oe_n, !rb1_v);
    if (rb1_v)
      check(addr_out, rb1_d);
    check(data_tristate, rb1_v && rb1_t);
    eo = o;
    // Host issues no load while the port's readback is on the address pins
    if (rb1_v && (o == op_cnt_load || o == op_msk_load))
      eo = op_cnt_inc;
    rb1_v = rb0_v;
    rb1_d = rb0_d;
    rb1_t = rb0_t;
    op = eo;
    data = d;
    {ce_lo, ce_hi} = 2'($random(seed));
    rb0_v = 0;
    rb0_t = !ce_lo && ce_hi;
    if (tie_wrap && e_wrap == 0 && eo <= op_cnt_hold)
      eo = op_cnt_reset;
    case (eo)
      op_cnt_reset:
      begin
        e_cnt &= ~e_msk;
        e_mir &= ~e_msk;
        e_wrap = 1;
      end
      op_cnt_load:
      begin
        e_cnt = d;
        e_mir = d;
        e_wrap = 1;
      end
      op_cnt_read:
      begin
        rb0_v = 1;
        rb0_d = e_cnt;
      end
      op_cnt_inc:
      begin
        if ((e_cnt & e_msk) == e_msk)
          e_cnt = (e_cnt & ~e_msk) | (e_mir & e_msk);
        else
          e_cnt = (e_cnt & ~e_msk) | (((e_cnt | ~e_msk) + 1) & e_msk);
        e_wrap = (e_cnt & e_msk) != e_msk;
      end
      op_msk_reset:
      begin
        e_msk = ALL;
        e_wrap = 1;
      end
      op_msk_load:
      begin
        e_msk = d;
        e_wrap = 1;
      end
      op_msk_read:
      begin
        rb0_v = 1;
        rb0_d = e_msk;
      end
      default:
        ;
    endcase
  endtask

  task automatic mreset;
    @(negedge clk_sys);
    op = op_cnt_hold;
    master_reset_n = 1'h0;
    #5;
    check(counter_addr, 0);
    check(mask_value, ALL);
    check(wrap_flag_n, 1);
    repeat (2) @(negedge clk_sys);
    master_reset_n = 1'h1;
    repeat (3) @(posedge clk_sys);
    model_reset;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #1000000;
    fails++;
    end_of_test;
  end

  initial
  begin
    repeat (10) @(negedge clk_sys);
    srst = 1'h0;
    model_reset;
    step(op_msk_load, 17'h0003F);
    step(op_cnt_load, 17'h00008);
    repeat (60) step(op_cnt_inc, '0);
    repeat (3) step(op_cnt_hold, '0);
    step(op_cnt_read, '0);
    step(op_msk_read, '0);
    step(op_reserved, '0);
    step(op_cnt_hold, '0);
    step(op_msk_load, 17'h0003E);
    step(op_cnt_load, 17'h1FFC5);
    repeat (40) step(op_cnt_inc, '0);
    step(op_msk_load, 17'h0000F);
    step(op_cnt_load, 17'h1ABCD);
    step(op_cnt_reset, '0);
    repeat (20) step(op_cnt_inc, '0);
    step(op_msk_reset, '0);
    step(op_cnt_reset, '0);
    step(op_msk_load, 17'h00007);
    step(op_cnt_load, 17'h00013);
    tie_wrap = 1'h1;
    repeat (12) step(op_cnt_inc, '0);
    tie_wrap = 1'h0;
    mreset;
    step(op_msk_load, 17'h00003);
    repeat (6) step(op_cnt_inc, '0);
    // Upper bits moved past the mirror, so a wrap must keep them
    step(op_msk_reset, '0);
    step(op_cnt_load, 17'h0000E);
    repeat (3) step(op_cnt_inc, '0);
    step(op_msk_load, 17'h00003);
    repeat (4) step(op_cnt_inc, '0);
    repeat (3000)
    begin
      ro = 4'($unsigned($random(seed)) % 9);
      rd = AW'($random(seed));
      if (ro == op_msk_load)
      begin
        n = 1 + $unsigned($random(seed)) % AW;
        rd = AW'((1 << n) - 1 - (n > 1 ? ($random(seed) & 1) : 0));
      end
      step(ro, rd);
    end
    repeat (3) step(op_cnt_hold, '0);
    end_of_test;
  end
endmodule
`default_nettype wire
